// File: dv/repeat_loop_control_tb.sv
// Self-checking bench for the repeat-loop control block
`timescale 1ns/1ps
`include "rlc_defines.svh"
module repeat_loop_control_tb;
	logic i_clk = 1'b0, i_reset_n = 1'b0, rpt_dec = 1'b0, rpt_zero = 1'b0, block_repeat_instruction_dec = 1'b0, rep_ok = 1'b1;
	logic mmr_we = 1'b0, block_repeat_active_flag_set = 1'b0, go = 1'b0, slow = 1'b0, two_word = 1'b0;
	logic [1:0] mmr_sel = 2'h0;
	logic [15:0] rpt_count = 16'h0, mmr_wdata = 16'h0, irq = 16'h0, ack = 16'h0, bs, be, bc;
	logic exec_v, fv, ftw, block_repeat_active_flag, hold, clr, pipe, nrep, redir, sup, mask;
	logic [15:0] fa, single_repeat_counter, brc, bsa, bea, tgt, interrupt_flag_register;
	logic [31:0] seed = 32'hC1D1;
	int n_errors = 0, n_checks = 0, i;
	always #12.5 i_clk = ~i_clk;
	rlc_core u_rlc_core (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_rpt_decode(rpt_dec), .i_rpt_zero(rpt_zero),
		.i_rpt_count(rpt_count), .i_block_repeat_instruction_decode(block_repeat_instruction_dec), .i_exec_valid(exec_v), .i_exec_repeatable(rep_ok),
		.i_fetch_valid(fv), .i_fetch_addr(fa), .i_fetch_two_word(ftw), .i_mmr_we(mmr_we), .i_mmr_sel(mmr_sel),
		.i_mmr_wdata(mmr_wdata), .i_block_repeat_active_flag_set(block_repeat_active_flag_set), .i_irq(irq), .i_irq_ack(ack),
		.o_single_repeat_counter(single_repeat_counter), .o_block_repeat_count(brc), .o_block_start_address(bsa),
		.o_block_end_address(bea), .o_block_repeat_active_flag(block_repeat_active_flag), .o_repeat_hold(hold),
		.o_clear_acc_product_register(clr), .o_pipeline_repeat(pipe), .o_not_repeatable(nrep), .o_fetch_redirect(redir),
		.o_fetch_target(tgt), .o_suppress_second_word(sup), .o_irq_mask(mask), .o_interrupt_flag_register(interrupt_flag_register));
	rlc_cpu_model u_rlc_cpu_model (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_go(go), .i_slow(slow),
		.i_two_word(two_word), .i_hold(hold), .i_redirect(redir), .i_target(tgt), .i_end(bea),
		.o_exec_valid(exec_v), .o_fetch_valid(fv), .o_fetch_addr(fa), .o_fetch_two_word(ftw));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task tick;
		@(posedge i_clk);
		#1;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task mmr(input logic [1:0] sel, input logic [15:0] d);
		mmr_we = 1'b1;
		mmr_sel = sel;
		mmr_wdata = d;
		tick;
	endtask
	// Counter is loaded by decode here; a register write also loads it while idle
	task srep(input logic [15:0] n, input logic z, input logic sl, input logic bad, input logic [15:0] irqb);
		int ne;
		int nn;
		ne = 0;
		nn = 0;
		slow = sl;
		rep_ok = !bad;
		rpt_zero = z;
		rpt_count = n;
		rpt_dec = 1'b1;
		irq = irqb;
		tick;
		rpt_count = ~n;
		chk(hold, 1'b1);
		chk(single_repeat_counter, n);
		chk(clr, z);
		chk(pipe, 1'b0);
		// Second decode while busy must not reload the count
		while (hold === 1'b1 && ne < 70000)
		begin
			@(posedge i_clk);
			if (exec_v === 1'b1)
				ne++;
			#1;
			rpt_dec = 1'b0;
			if (nrep === 1'b1)
				nn++;
			if (hold === 1'b1)
				chk(mask, 1'b1);
			if (hold === 1'b1 && ne > 0 && !bad)
				chk(pipe, 1'b1);
			if (hold === 1'b1 && ne == 4)
				chk(interrupt_flag_register, irqb);
		end
		chk(ne, bad ? 32'h1 : 32'(n) + 32'h1);
		chk(nn, bad);
		chk(single_repeat_counter, 16'h0);
		chk(interrupt_flag_register, irqb);
		irq = 16'h0;
		ack = irqb;
		tick;
		ack = 16'h0;
		tick;
		chk(interrupt_flag_register, 16'h0);
		chk(mask, 1'b0);
		$display("single repeat test done");
	endtask
	task blk(input logic [15:0] c, input logic [15:0] s, input logic [15:0] e, input logic tw, input logic vs);
		int nred;
		int nsup;
		int k;
		logic lastw;
		nred = 0;
		nsup = 0;
		two_word = tw;
		mmr(`RLC_SEL_BLOCK_REPEAT_COUNT, c);
		mmr(`RLC_SEL_BLOCK_START_ADDRESS, s);
		mmr(`RLC_SEL_BLOCK_END_ADDRESS, e);
		mmr_we = 1'b0;
		chk({brc, bsa}, {c, s});
		chk(bea, e);
		block_repeat_active_flag_set = vs;
		block_repeat_instruction_dec = !vs;
		tick;
		block_repeat_active_flag_set = 1'b0;
		block_repeat_instruction_dec = 1'b0;
		chk(block_repeat_active_flag, 1'b1);
		go = 1'b1;
		for (k = 0; k < 3000 && block_repeat_active_flag === 1'b1; k++)
		begin
			@(posedge i_clk);
			lastw = fv && (fa == e || fa == e - 16'h1);
			#1;
			if (lastw)
				chk(mask, 1'b1);
			if (redir === 1'b1)
				nred++;
			if (redir === 1'b1)
				chk(tgt, s);
			if (sup === 1'b1)
				nsup++;
		end
		go = 1'b0;
		chk(nred, c);
		chk(nsup, tw ? c : 16'h0);
		$display("block repeat test done");
	endtask
	initial
	begin
		repeat (4) @(posedge i_clk);
		#1;
		i_reset_n = 1'b1;
		chk(single_repeat_counter, 16'h0);
		chk({brc, hold, mask, block_repeat_active_flag, redir}, 20'h0);
		mmr(`RLC_SEL_SINGLE_REPEAT_COUNTER, 16'h0012);
		mmr_we = 1'b0;
		chk(single_repeat_counter, 16'h0012);
		srep(16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000);
		srep(16'hFFFF, 1'b1, 1'b0, 1'b0, 16'h0004);
		srep(16'h0005, 1'b0, 1'b0, 1'b1, 16'h0000);
		for (i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			srep({12'h0, seed[3:0]} + 16'h4, seed[4], seed[5], 1'b0, 16'h1 << seed[9:6]);
			seed = lfsr(seed);
			slow = seed[0];
			bc = 16'h1 + seed[13:11];
			bs = 16'h8 + seed[7:4];
			be = bs + 16'h2 + seed[10:8];
			blk(bc, bs, be, seed[14], 1'b0);
			blk(bc, bs, be, ~seed[14], 1'b1);
		end
		conclude;
	end
	initial
	begin
		#2400000;
		n_errors++;
		$display("watchdog expired");
		conclude;
	end
endmodule

// File: dv/rlc_cpu_model.sv
// Behavioural fetch and execute stage that drives the repeat-loop control
`timescale 1ns/1ps
module rlc_cpu_model
(
	// Clock, reset, pacing and two-word select
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_go,
	input wire logic i_slow,
	input wire logic i_two_word,
	// From the repeat control
	input wire logic i_hold,
	input wire logic i_redirect,
	input wire logic [15:0] i_target,
	input wire logic [15:0] i_end,
	// Stage outputs
	output logic o_exec_valid = 1'b0,
	output logic o_fetch_valid = 1'b0,
	output logic [15:0] o_fetch_addr = 16'h0000,
	output logic o_fetch_two_word = 1'b0
);
	logic [2:0] pace = 3'h0;
	// Fixed stall pattern keeps slow runs repeatable
	always @(posedge i_clk)
	begin
		#1;
		pace = pace + 3'h1;
		o_exec_valid = i_reset_n && i_hold && !(i_slow && pace[1:0] == 2'h3);
		if (!i_go || !i_reset_n)
			o_fetch_addr = 16'h0000;
		else if (i_redirect)
			o_fetch_addr = i_target;
		else if (o_fetch_valid)
			o_fetch_addr = o_fetch_addr + 16'h0001;
		o_fetch_valid = i_reset_n && i_go && !(i_slow && pace == 3'h5);
		o_fetch_two_word = i_two_word && o_fetch_addr == i_end;
	end
endmodule

// File: src/rlc_core.sv
// Single and block repeat control with interrupt deferral
`timescale 1ns/1ps
`include "rlc_defines.svh"

// Summary of operation
// RULE_01: Single-repeat counter is 16 bits; value N runs next instruction N+1 times.
// RULE_02: Only the two repeat instructions load the counter; at most 65,536 runs. Code also loads it from a register write while idle.
// RULE_03: Reset clears the single-repeat counter to zero.
// RULE_04: Zeroing repeat clears accumulator and product register before first repetition.
// RULE_05: From repeat decode until loop completion, all interrupts but reset are masked.
// RULE_06: Software should not write the single-repeat counter directly.
// RULE_07: Repeated multicycle instructions are pipelined, completing one per cycle.
// RULE_08: Branches, calls, returns, idle, traps, immediates are never repeated.
// RULE_09: One set of block registers; nesting needs software save and restore.
// RULE_10: Software sets block end address to last word of the block.
// RULE_11: End on first word of two-word instruction substitutes loop's first instruction.
// RULE_12: PC holds start address before last instruction executes; calls push it.
// RULE_13: No interrupt path while last two words of a block are fetched.
// RULE_14: Interrupt in final words: taken at loop top, or after exit on last pass.
// RULE_15: Interrupts and calls inside a block trap out; the block resumes on return.
// RULE_16: Single repeats and aux-not-zero branch loops work inside an active block.
// RULE_17: Setting the active flag re-arms the restored outer block loop.
// RULE_18: Incoming interrupts are latched at once even when the branch is deferred.
// RULE_19: A latched interrupt stays in the flag register until recognised.
// RULE_20: At end address fetch, counter decrements and loops while nonzero, else falls through.
module rlc_core
	import rlc_pkg::*;
#(
	parameter int CNT_W = `RLC_CNT_W,
	parameter int ADDR_W = `RLC_ADDR_W,
	parameter int IRQ_W = `RLC_IRQ_W
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Decode of repeat instructions
	input wire logic i_rpt_decode,
	input wire logic i_rpt_zero,
	input wire logic [CNT_W-1:0] i_rpt_count,
	input wire logic i_block_repeat_instruction_decode,
	// Executed instruction class from decode
	input wire logic i_exec_valid,
	input wire logic i_exec_repeatable,
	// Fetch stage
	input wire logic i_fetch_valid,
	input wire logic [ADDR_W-1:0] i_fetch_addr,
	input wire logic i_fetch_two_word,
	// Memory-mapped register writes
	input wire logic i_mmr_we,
	input wire logic [`RLC_REG_SEL_W-1:0] i_mmr_sel,
	input wire logic [CNT_W-1:0] i_mmr_wdata,
	input wire logic i_block_repeat_active_flag_set,
	// Interrupts
	input wire logic [IRQ_W-1:0] i_irq,
	input wire logic [IRQ_W-1:0] i_irq_ack,
	// Status and control outputs
	output logic [CNT_W-1:0] o_single_repeat_counter,
	output logic [CNT_W-1:0] o_block_repeat_count,
	output logic [ADDR_W-1:0] o_block_start_address,
	output logic [ADDR_W-1:0] o_block_end_address,
	output logic o_block_repeat_active_flag,
	output logic o_repeat_hold,
	output logic o_clear_acc_product_register,
	output logic o_pipeline_repeat,
	output logic o_not_repeatable,
	output logic o_fetch_redirect,
	output logic [ADDR_W-1:0] o_fetch_target,
	output logic o_suppress_second_word,
	output logic o_irq_mask,
	output logic [IRQ_W-1:0] o_interrupt_flag_register
);
	rlc_srep_type srep_q, srep_d;
	logic [CNT_W-1:0] single_repeat_counter_q, single_repeat_counter_d;
	logic [CNT_W-1:0] block_repeat_count_q, block_repeat_count_d;
	logic [ADDR_W-1:0] block_start_address_q, block_start_address_d;
	logic [ADDR_W-1:0] block_end_address_q, block_end_address_d;
	logic block_repeat_active_flag_q, block_repeat_active_flag_d;
	logic [IRQ_W-1:0] irq_s1_q, irq_s2_q, irq_s3_q;
	logic [IRQ_W-1:0] ifr_q, ifr_d;
	logic hold_q, zero_q, pipe_q, nrep_q, redir_q, supp_q, mask_q;
	logic [ADDR_W-1:0] target_q;
	logic near_end_q;

	// Decode of fetch position within the block, repeat state, interrupt edges and register selects
	wire logic at_end = block_repeat_active_flag_q && i_fetch_valid && (i_fetch_addr == block_end_address_q);
	wire logic [ADDR_W-1:0] end_m1 = block_end_address_q - ADDR_W'(1);
	wire logic at_end_m1 = block_repeat_active_flag_q && i_fetch_valid && (i_fetch_addr == end_m1);
	wire logic loop_back = at_end && (block_repeat_count_q != '0);
	wire logic srep_busy = (srep_q != RLC_IDLE);
	wire logic srep_last = (srep_q == RLC_RUN) && i_exec_valid && (single_repeat_counter_q == '0);
	wire logic irq_edge_any = |(irq_s2_q & ~irq_s3_q);
	wire logic near_end = at_end || at_end_m1;
	wire logic mmr_single_repeat_counter = i_mmr_we && (i_mmr_sel == `RLC_SEL_SINGLE_REPEAT_COUNTER);
	wire logic mmr_block_repeat_count = i_mmr_we && (i_mmr_sel == `RLC_SEL_BLOCK_REPEAT_COUNT);
	wire logic mmr_block_start_address = i_mmr_we && (i_mmr_sel == `RLC_SEL_BLOCK_START_ADDRESS);
	wire logic mmr_block_end_address = i_mmr_we && (i_mmr_sel == `RLC_SEL_BLOCK_END_ADDRESS);

	// Single repeat state machine
	always_comb
	begin
		srep_d = srep_q;
		single_repeat_counter_d = single_repeat_counter_q;
		case (srep_q)
			RLC_IDLE:
			begin
				if (i_rpt_decode)
				begin
					srep_d = RLC_ARMED; // see RULE_05
					single_repeat_counter_d = i_rpt_count; // see RULE_01 RULE_02
				end
				else if (mmr_single_repeat_counter)
				begin
					single_repeat_counter_d = i_mmr_wdata; // see RULE_06
				end
			end
			RLC_ARMED:
			begin
				if (i_exec_valid)
				begin
					if (!i_exec_repeatable)
					begin
						srep_d = RLC_IDLE; // see RULE_08
						single_repeat_counter_d = '0;
					end
					else if (single_repeat_counter_q == '0)
					begin
						srep_d = RLC_IDLE;
					end
					else
					begin
						srep_d = RLC_RUN;
						single_repeat_counter_d = single_repeat_counter_q - CNT_W'(1);
					end
				end
			end
			RLC_RUN:
			begin
				if (i_exec_valid)
				begin
					if (single_repeat_counter_q == '0)
					begin
						srep_d = RLC_IDLE; // see RULE_01
					end
					else
					begin
						single_repeat_counter_d = single_repeat_counter_q - CNT_W'(1); // see RULE_07
					end
				end
			end
			default:
			begin
				srep_d = RLC_IDLE;
				single_repeat_counter_d = '0;
			end
		endcase
	end

	// Block repeat registers; block counter steps only on end fetch
	always_comb
	begin
		block_repeat_count_d = mmr_block_repeat_count ? i_mmr_wdata : block_repeat_count_q; // see RULE_09
		block_start_address_d = mmr_block_start_address ? i_mmr_wdata[ADDR_W-1:0] : block_start_address_q;
		block_end_address_d = mmr_block_end_address ? i_mmr_wdata[ADDR_W-1:0] : block_end_address_q; // see RULE_10
		block_repeat_active_flag_d = block_repeat_active_flag_q;
		if (at_end)
		begin
			if (loop_back)
			begin
				block_repeat_count_d = block_repeat_count_q - CNT_W'(1); // see RULE_20
			end
			else
			begin
				block_repeat_active_flag_d = 1'b0; // see RULE_20
			end
		end
		if (i_block_repeat_instruction_decode || i_block_repeat_active_flag_set)
		begin
			block_repeat_active_flag_d = 1'b1; // see RULE_17
		end
	end

	// Flags set by hardware win over acknowledge
	assign ifr_d = (ifr_q & ~i_irq_ack) | (irq_s2_q & ~irq_s3_q); // see RULE_18 RULE_19

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			srep_q <= RLC_IDLE;
			single_repeat_counter_q <= `RLC_SINGLE_REPEAT_COUNTER_RESET; // see RULE_03
			block_repeat_count_q <= `RLC_BLOCK_REPEAT_COUNT_RESET;
			block_start_address_q <= `RLC_ADDR_RESET;
			block_end_address_q <= `RLC_ADDR_RESET;
			block_repeat_active_flag_q <= 1'b0;
			ifr_q <= `RLC_IRQ_RESET;
			near_end_q <= 1'b0;
		end
		else
		begin
			srep_q <= srep_d;
			single_repeat_counter_q <= single_repeat_counter_d;
			block_repeat_count_q <= block_repeat_count_d;
			block_start_address_q <= block_start_address_d;
			block_end_address_q <= block_end_address_d;
			block_repeat_active_flag_q <= block_repeat_active_flag_d;
			ifr_q <= ifr_d;
			near_end_q <= near_end;
		end
	end

	// Interrupt pins are asynchronous; third stage is the edge history
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			irq_s1_q <= '0;
			irq_s2_q <= '0;
			irq_s3_q <= '0;
		end
		else
		begin
			irq_s1_q <= i_irq;
			irq_s2_q <= irq_s1_q;
			irq_s3_q <= irq_s2_q;
		end
	end

	// Registered control outputs
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			hold_q <= 1'b0;
			zero_q <= 1'b0;
			pipe_q <= 1'b0;
			nrep_q <= 1'b0;
			redir_q <= 1'b0;
			target_q <= '0;
			supp_q <= 1'b0;
			mask_q <= 1'b0;
		end
		else
		begin
			hold_q <= (srep_d != RLC_IDLE);
			zero_q <= i_rpt_decode && i_rpt_zero && !srep_busy; // see RULE_04
			pipe_q <= (srep_d == RLC_RUN); // see RULE_07
			nrep_q <= (srep_q == RLC_ARMED) && i_exec_valid && !i_exec_repeatable; // see RULE_08
			// Redirect at end fetch so PC holds the top before the last executes
			redir_q <= loop_back; // see RULE_12 RULE_15 RULE_16
			target_q <= block_start_address_q;
			supp_q <= loop_back && i_fetch_two_word; // see RULE_11
			// Masked during single repeat and final two words of a block
			mask_q <= i_rpt_decode || (srep_d != RLC_IDLE) || near_end; // see RULE_05 RULE_13 RULE_14
		end
	end

	assign o_single_repeat_counter = single_repeat_counter_q;
	assign o_block_repeat_count = block_repeat_count_q;
	assign o_block_start_address = block_start_address_q;
	assign o_block_end_address = block_end_address_q;
	assign o_block_repeat_active_flag = block_repeat_active_flag_q;
	assign o_repeat_hold = hold_q;
	assign o_clear_acc_product_register = zero_q;
	assign o_pipeline_repeat = pipe_q;
	assign o_not_repeatable = nrep_q;
	assign o_fetch_redirect = redir_q;
	assign o_fetch_target = target_q;
	assign o_suppress_second_word = supp_q;
	assign o_irq_mask = mask_q;
	assign o_interrupt_flag_register = ifr_q;

	a_single_repeat_counter_reset_zero: assert property (@(posedge i_clk) $rose(i_reset_n) |-> single_repeat_counter_q == '0) // see RULE_03
		else $error("repeat counter not zero after reset");
	a_rpt_load_count: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_rpt_decode && !srep_busy) |=> single_repeat_counter_q == $past(i_rpt_count)) // see RULE_01
		else $error("repeat counter not loaded");
	a_rpt_step_down: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		((srep_q == RLC_RUN) && i_exec_valid && single_repeat_counter_q != '0) |=> single_repeat_counter_q == $past(single_repeat_counter_q) - CNT_W'(1)) // see RULE_07
		else $error("repeat counter did not step");
	a_repeat_with_zeroing_clears: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_rpt_decode && i_rpt_zero && !srep_busy) |=> o_clear_acc_product_register) // see RULE_04
		else $error("zeroing repeat did not clear");
	a_rpt_masks_irq: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		srep_busy |-> o_irq_mask) // see RULE_05
		else $error("interrupt unmasked during repeat");
	a_rpt_ends_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		srep_last |=> srep_q == RLC_IDLE ##1 !o_pipeline_repeat) // see RULE_01
		else $error("repeat did not end");
	a_nonrep_abort: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		((srep_q == RLC_ARMED) && i_exec_valid && !i_exec_repeatable) |=> o_not_repeatable && srep_q == RLC_IDLE) // see RULE_08
		else $error("nonrepeatable instruction repeated");
	a_end_mask_irq: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		near_end |=> o_irq_mask) // see RULE_13
		else $error("interrupt open in block tail");
	a_loop_redirect: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		loop_back |=> o_fetch_redirect && o_fetch_target == $past(block_start_address_q) && block_repeat_count_q == $past(block_repeat_count_q) - CNT_W'(1)) // see RULE_20
		else $error("block loop did not redirect");
	a_loop_exit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(at_end && block_repeat_count_q == '0 && !i_block_repeat_active_flag_set && !i_block_repeat_instruction_decode) |=> !block_repeat_active_flag_q && !o_fetch_redirect) // see RULE_20
		else $error("block loop did not exit");
	a_two_word_sub: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(loop_back && i_fetch_two_word) |=> o_suppress_second_word) // see RULE_11
		else $error("second word not substituted");
	a_irq_latched: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(irq_s2_q[0] && !irq_s3_q[0]) |=> ifr_q[0]) // see RULE_18
		else $error("interrupt not latched");
	a_irq_held: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(ifr_q[0] && !i_irq_ack[0]) |=> ifr_q[0]) // see RULE_19
		else $error("latched interrupt lost");
	a_block_repeat_active_flag_rearm: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_block_repeat_active_flag_set |=> block_repeat_active_flag_q) // see RULE_17
		else $error("active flag not re-armed");
	a_irq_edge_seen: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		irq_edge_any |=> |ifr_q)
		else $error("interrupt edge dropped");
	a_near_end_track: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		near_end_q |-> o_irq_mask) // see RULE_14
		else $error("tail mask missing");
	// Busy repeat must refuse a fresh load of its counter
	a_rpt_refuse_busy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(srep_busy && i_rpt_decode && !i_exec_valid) |=> single_repeat_counter_q == $past(single_repeat_counter_q)) // see RULE_02
		else $error("busy repeat counter reloaded");
	a_pipe_in_run: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(srep_q == RLC_RUN) |-> o_pipeline_repeat) // see RULE_07
		else $error("repeat run not pipelined");
	a_hold_tracks: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		srep_busy |-> o_repeat_hold) // see RULE_05
		else $error("repeat hold missing");
	a_zero_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_clear_acc_product_register |=> !o_clear_acc_product_register) // see RULE_04
		else $error("clear pulse too long");
	a_block_repeat_instruction_arms: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_block_repeat_instruction_decode |=> block_repeat_active_flag_q) // see RULE_17
		else $error("block repeat not armed");
	a_target_start: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		loop_back |=> o_fetch_target == $past(block_start_address_q)) // see RULE_12
		else $error("redirect target not block start");
	a_single_repeat_counter_mmr_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(mmr_single_repeat_counter && !srep_busy && !i_rpt_decode) |=> single_repeat_counter_q == $past(i_mmr_wdata)) // see RULE_06
		else $error("counter register write lost");
endmodule

// File: src/rlc_defines.svh
// Constants for the repeat-loop control block
`ifndef RLC_DEFINES_SVH
`define RLC_DEFINES_SVH
`define RLC_CNT_W 16
`define RLC_ADDR_W 16
`define RLC_IRQ_W 16
`define RLC_SINGLE_REPEAT_COUNTER_RESET 16'h0000
`define RLC_BLOCK_REPEAT_COUNT_RESET 16'h0000
`define RLC_ADDR_RESET 16'h0000
`define RLC_IRQ_RESET 16'h0000
`define RLC_REG_SEL_W 2
`define RLC_SEL_SINGLE_REPEAT_COUNTER 2'h0
`define RLC_SEL_BLOCK_REPEAT_COUNT 2'h1
`define RLC_SEL_BLOCK_START_ADDRESS 2'h2
`define RLC_SEL_BLOCK_END_ADDRESS 2'h3
`endif

// File: src/rlc_pkg.sv
// Types for the repeat-loop control block
package rlc_pkg;
	typedef enum logic [1:0]
	{
		RLC_IDLE = 2'b00,
		RLC_ARMED = 2'b01,
		RLC_RUN = 2'b10
	} rlc_srep_type;
endpackage
